// ===== dv/rom_partner.sv
`timescale 1ns/1ps

// far side: serial rom on the data lines plus the board strap on the shared pin
module rom_partner (
    input  wire logic clock,               // system clock
    input  wire logic rom_clk,             // serial clock from device
    input  wire logic rom_select_n,        // rom select, active low
    input  wire logic rom_speed_strap_out, // device drive value
    input  wire logic rom_speed_strap_oe,  // device drive enable
    input  wire logic strap_pull_down,     // device weak pull-down
    input  wire logic strap_pullup,        // board strap fitted high
    output logic      rom_speed_strap_in,  // resolved pin level
    output logic      rom_data_in          // rom data to device
);
    logic [7:0] shift_reg = 8'h6C;         // rom data pattern
    logic       last_reg  = 1'h0;          // last pin level
    // strap resistor beats the weak pull-down; a bare pin drifts
    always_comb begin
        if (rom_speed_strap_oe) begin
            rom_speed_strap_in = rom_speed_strap_out;
        end else if (strap_pullup) begin
            rom_speed_strap_in = 1'h1;
        end else if (strap_pull_down) begin
            rom_speed_strap_in = 1'h0;
        end else begin
            rom_speed_strap_in = !last_reg;
        end
    end
    // rom shifts only while selected and clocked
    always_ff @(posedge clock) begin
        last_reg <= rom_speed_strap_in;
        if (!rom_select_n && rom_clk) begin
            shift_reg <= {shift_reg[6:0], shift_reg[7]};
        end
    end
    // deselected rom releases the line, the pull-down wins
    assign rom_data_in = rom_select_n ? 1'h0 : shift_reg[7];
endmodule

// ===== dv/strap_properties.sv
`timescale 1ns/1ps

// pin rules around reset release and in low-power states
module strap_properties
    import strap_pkg::*;
#(
    parameter int PWR_WIDTH = CARD_PWR_WIDTH
) (
    input wire logic                 clock,
    input wire logic                 rstn,
    input wire logic                 suspend,
    input wire logic                 power_down,
    input wire logic                 rom_port_enable,
    input wire logic [PWR_WIDTH-1:0] card_pwr_cfg,
    input wire logic                 general_out_req,
    input wire logic                 rom_speed_strap_in,
    input wire logic                 rom_data_in,
    input wire logic                 rom_speed_strap_out,
    input wire logic                 rom_speed_strap_oe,
    input wire logic                 strap_pull_down,
    input wire logic                 data_in_pull_down,
    input wire logic                 rom_clk,
    input wire logic                 rom_select_n,
    input wire logic                 rom_data_bit,
    input wire logic                 fast_speed,
    input wire logic                 card_slot_power,
    input wire logic                 general_output_one,
    input wire logic                 general_output_one_oe
);
    logic [1:0] rel_cnt_reg; // edges since release
    logic       run_ok;      // capture phase over
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // saturating count keeps the capture phase out of run checks
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rel_cnt_reg <= 2'h0;
        end else if (rel_cnt_reg != 2'h3) begin
            rel_cnt_reg <= rel_cnt_reg + 2'h1;
        end
    end
    assign run_ok = (rel_cnt_reg == 2'h3);
    a_reset_float: assert property ($rose(rstn) |-> strap_pull_down && !rom_speed_strap_oe)
        else $error("strap pin not floated at release");
    a_strap_latch: assert property ($rose(rstn) |=> fast_speed == $past(rom_speed_strap_in))
        else $error("strap level not latched");
    a_pull_off: assert property ($rose(rstn) |-> ##2 !strap_pull_down)
        else $error("pull-down still on");
    a_speed_hold: assert property (rstn && $past(rstn) && $past(rstn, 2) |-> $stable(fast_speed))
        else $error("speed changed in run");
    a_clk_quiet: assert property ($rose(rstn) |-> !rom_clk ##1 !rom_clk)
        else $error("serial clock moved early");
    a_sus_low: assert property (run_ok && suspend && !fast_speed |=> rom_speed_strap_oe && !rom_speed_strap_out)
        else $error("pin not driven low in suspend");
    a_sus_float: assert property (run_ok && suspend && fast_speed |=> !rom_speed_strap_oe)
        else $error("pin driven in suspend");
    a_select_off: assert property (rom_port_enable && power_down |=> rom_select_n)
        else $error("select low in power-down");
    a_card_drive: assert property (run_ok |-> card_slot_power == (|$past(card_pwr_cfg)))
        else $error("card power mismatch");
    a_general_out: assert property (run_ok |-> general_output_one_oe && general_output_one == $past(general_out_req))
        else $error("general pin mismatch");
    a_data_in: assert property (run_ok |-> data_in_pull_down && rom_data_bit == $past(rom_data_in))
        else $error("data-in path mismatch");
endmodule

bind boot_rom_port_strap_control strap_properties #(.PWR_WIDTH(PWR_WIDTH)) props_i (.clock, .rstn, .suspend,
    .power_down, .rom_port_enable, .card_pwr_cfg, .general_out_req, .rom_speed_strap_in, .rom_data_in,
    .rom_speed_strap_out, .rom_speed_strap_oe, .strap_pull_down, .data_in_pull_down, .rom_clk, .rom_select_n,
    .rom_data_bit, .fast_speed, .card_slot_power, .general_output_one, .general_output_one_oe);

// ===== dv/testbench.sv
`timescale 1ns/1ps

module testbench
    import strap_pkg::*;
();
    logic clock, rstn, suspend, power_down, rom_port_enable, general_out_req, strap_pullup;
    logic rom_speed_strap_in, rom_data_in, rom_speed_strap_out, rom_speed_strap_oe, strap_pull_down;
    logic data_in_pull_down, rom_clk, rom_select_n, rom_data_bit, fast_speed, card_slot_power;
    logic general_output_one, general_output_one_oe;
    rom_req_type rom_req;      // core serial request
    logic [3:0]  card_pwr_cfg; // config bits
    int          err_total;    // mismatches
    int          cmp_count;    // comparisons
    boot_rom_port_strap_control boot_rom_port_strap_control_i (.clock, .rstn, .suspend, .power_down,
        .rom_port_enable, .rom_req, .card_pwr_cfg, .general_out_req, .rom_speed_strap_in, .rom_data_in,
        .rom_speed_strap_out, .rom_speed_strap_oe, .strap_pull_down, .data_in_pull_down, .rom_clk,
        .rom_select_n, .rom_data_bit, .fast_speed, .card_slot_power, .general_output_one, .general_output_one_oe);
    rom_partner rom_partner_i (.clock, .rom_clk, .rom_select_n, .rom_speed_strap_out, .rom_speed_strap_oe,
        .strap_pull_down, .strap_pullup, .rom_speed_strap_in, .rom_data_in);
    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // long reset with a chosen strap, then the latch and pull-down release
    task automatic do_reset(input logic strap);
        @(posedge clock);
        rstn <= 1'h0;
        strap_pullup <= strap;
        repeat (26) @(posedge clock); // over one microsecond
        @(negedge clock);
        check("reset pins", {data_in_pull_down, rom_clk, rom_speed_strap_oe, strap_pull_down}, 4'h9);
        @(posedge clock);
        rstn <= 1'h1;
        repeat (3) @(negedge clock);
        check("speed", {3'h0, fast_speed}, {3'h0, strap});
        check("pull off", {3'h0, strap_pull_down}, 4'h0);
        check("data-out role", {2'h0, rom_speed_strap_oe, rom_speed_strap_out}, 4'h3);
    endtask
    // core asks to drive high; suspend must override per strap
    task automatic t_suspend(input logic strap);
        @(posedge clock);
        suspend <= 1'h1;
        repeat (2) @(negedge clock);
        check("suspend oe", {3'h0, rom_speed_strap_oe}, {3'h0, !strap});
        if (!strap) check("suspend out", {3'h0, rom_speed_strap_out}, 4'h0);
        @(posedge clock);
        suspend <= 1'h0;
        repeat (2) @(negedge clock);
        check("resume", {2'h0, rom_speed_strap_oe, rom_speed_strap_out}, 4'h3);
    endtask
    // every card field value, general pin, power-down select, data-in path
    task automatic t_misc(input logic strap);
        logic d;
        for (int i = 0; i < 16; i++) begin
            @(posedge clock);
            card_pwr_cfg <= 4'(i);
            general_out_req <= i[0];
            rom_req.clk <= i[0];
            rom_req.data <= i[1];
            rom_req.data_oe <= i[2];
            rom_port_enable <= (i != 5);
            power_down <= (i == 9);
            @(negedge clock);
            d = rom_data_in;
            @(negedge clock);
            check("card", {3'h0, card_slot_power}, {3'h0, i != 0});
            check("general", {2'h0, general_output_one_oe, general_output_one}, {2'h1, i[0]});
            check("select", {3'h0, rom_select_n}, {3'h0, (i == 5) || (i == 9)});
            check("serial clock", {3'h0, rom_clk}, {3'h0, i[0]});
            check("data out", {2'h0, rom_speed_strap_oe, rom_speed_strap_out}, {2'h0, i[2], i[1]});
            check("data in", {2'h0, data_in_pull_down, rom_data_bit}, {2'h1, d});
            check("speed held", {3'h0, fast_speed}, {3'h0, strap});
        end
    endtask
    initial begin
        clock = 1'h0;
        forever #20 clock = ~clock;
    end
    initial begin
        #(40 * 3000);
        err_total++;
        finish_test();
    end
    initial begin
        {rstn, suspend, power_down, general_out_req, strap_pullup} = 5'h0;
        rom_port_enable = 1'h1;
        rom_req = 4'h7;
        card_pwr_cfg = 4'h0;
        err_total = 0;
        cmp_count = 0;
        do_reset(1'h0);
        t_suspend(1'h0);
        t_misc(1'h0);
        do_reset(1'h1);
        t_suspend(1'h1);
        t_misc(1'h1);
        finish_test();
    end
endmodule

// ===== hdl/boot_rom_port_strap_control.sv
`timescale 1ns/1ps

// Notes on behaviour
// R1 - in reset, float strap pin with pull-down
// R2 - on release, latch strap, restore data-out
// R3 - pull-down off after reset release
// R4 - strap 0 gives 30 MHz, 1 gives 60
// R5 - strap 1: data-out floats in suspend
// R6 - strap 0: data-out driven low in suspend
// R7 - system holds reset low at least 1 us
// R8 - data-in pin with weak pull-down
// R9 - card power from config bits 3:0
// R10 - general pin is output only
// R11 - serial clock low during reset
// R12 - select active low, high in power-down
// R13 - strap held in register until next reset
module boot_rom_port_strap_control
    import strap_pkg::*;
#(
    parameter int PWR_WIDTH = CARD_PWR_WIDTH       // card power field width
) (
    input  wire logic                 clock,            // 25 MHz system clock
    input  wire logic                 rstn,             // chip reset, active low
    input  wire logic                 suspend,          // chip in suspend
    input  wire logic                 power_down,       // chip in power-down
    input  wire logic                 rom_port_enable,  // serial port enabled
    input  wire rom_req_type          rom_req,          // core request for serial port
    input  wire logic [PWR_WIDTH-1:0] card_pwr_cfg,     // config register bits 3:0
    input  wire logic                 general_out_req,  // core value for general pin
    input  wire logic                 rom_speed_strap_in, // data-out/strap pin level
    input  wire logic                 rom_data_in,      // data from the rom
    output logic                      rom_speed_strap_out, // data-out pin value
    output logic                      rom_speed_strap_oe,  // data-out pin enable
    output logic                      strap_pull_down,  // weak pull-down on strap pin
    output logic                      data_in_pull_down, // weak pull-down on data-in
    output logic                      rom_clk,          // serial clock to rom
    output logic                      rom_select_n,     // rom chip select, active low
    output logic                      rom_data_bit,     // sampled data-in bit
    output logic                      fast_speed,       // high when 60 MHz chosen
    output logic                      card_slot_power,  // card power drive gate
    output logic                      general_output_one, // general output pin
    output logic                      general_output_one_oe // general pin enable
);

    // strap capture state
    strap_phase_type phase_reg;          // strap pin phase
    strap_phase_type phase_next;         // next phase
    logic            speed_reg;          // latched strap value
    // data-out pin drive
    pin_drive_type   data_drive_next;    // wanted data-out pin drive
    pin_drive_type   data_drive_reg;     // registered data-out pin drive
    // registered pins
    logic            clk_reg;            // registered serial clock
    logic            select_n_reg;       // registered chip select
    logic            data_bit_reg;       // registered data-in sample
    logic            card_reg;           // registered card power
    logic            gpo_reg;            // registered general output
    logic            data_pull_reg;      // registered data-in pull-down
    logic            gpo_oe_reg;         // registered general pin enable

    // phase walks from reset through one capture edge into run
    // capture lasts one edge so the pin is still floated when read
    always_comb begin
        case (phase_reg)
            PHASE_RESET:   phase_next = PHASE_CAPTURE;
            PHASE_CAPTURE: phase_next = PHASE_RUN;
            PHASE_RUN:     phase_next = PHASE_RUN;
            default:       phase_next = PHASE_RESET;
        endcase
    end

    // phase register, constant under reset
    // a glitch on reset restarts capture from the top
    // release is seen on the first clock edge after rstn rises
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            phase_reg <= PHASE_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // strap caught on first edge after release, pin still floated then
    // a clocked catch avoids loading a port value under async reset
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // slow rate until the strap is read again
            speed_reg <= SPEED_SLOW;
        end else if (phase_reg == PHASE_RESET) begin
            // only the first edge after release loads it
            speed_reg <= rom_speed_strap_in;                        // R2 R13
        end
        // no else: the value stands until the next reset
    end

    // data-out pin drive by phase and suspend
    always_comb begin
        // default: floated, pull-down off, output low
        data_drive_next = '0;
        if (phase_reg == PHASE_RESET) begin
            // still sampling: keep floated with pull-down
            data_drive_next.pull_down = 1'b1;                       // R1
        end else if (suspend) begin
            // low-power drive depends on the latched strap
            if (speed_reg == SPEED_FAST) begin
                // fast strap: leave the line floating
                data_drive_next.oe = 1'b0;                          // R5
            end else begin
                // slow strap: hold it low so it cannot drift
                data_drive_next.oe  = 1'b1;                         // R6
                data_drive_next.out = 1'b0;
            end
        end else begin
            // back to data-out role, pull-down released
            data_drive_next.pull_down = 1'b0;                       // R3
            data_drive_next.oe        = rom_req.data_oe;            // R2
            data_drive_next.out       = rom_req.data;
        end
    end

    // registered pin drive, floated with pull-down in reset
    // reset value equals the in-reset drive, so entry never glitches the pin
    pin_driver #(
        .RESET_DRIVE('{out: 1'b0, oe: 1'b0, pull_down: 1'b1})
    ) u_data_pin (
        .clock     (clock),
        .rstn      (rstn),
        .drive_next(data_drive_next),
        .drive_reg (data_drive_reg)
    );

    // serial clock low in reset and until run, then from core
    // the release edge and the capture edge keep it low too
    // the rate divider lives in the core; this stage only gates and registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clk_reg <= 1'b0;                                        // R11
        end else begin
            clk_reg <= (phase_reg == PHASE_RUN) && rom_req.clk;
        end
    end

    // select high whenever idle or in power-down with port enabled
    // the power-down gate wins over any core request
    // a disabled port keeps select high as well
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            select_n_reg <= 1'b1;
        end else if (rom_port_enable && power_down) begin
            select_n_reg <= 1'b1;                                   // R12
        end else begin
            select_n_reg <= !(rom_port_enable && rom_req.select);   // R12
        end
    end

    // data-in sample; pin only ever received
    // the pin's pull-down keeps it low while the rom is deselected
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            data_bit_reg <= 1'b0;
        end else begin
            data_bit_reg <= rom_data_in;                            // R8
        end
    end

    // card power gate from any of the four config bits
    // any set bit turns the drive on; individual bits pick no level
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // reset keeps the slot unpowered
            card_reg <= 1'b0;
        end else begin
            card_reg <= |card_pwr_cfg;                              // R9
        end
    end

    // general pin follows the core, never sampled
    // no input path exists, so nothing can be read back
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            // pin starts low
            gpo_reg <= 1'b0;
        end else begin
            gpo_reg <= general_out_req;                             // R10
        end
    end

    // data-in pull-down stays on in and out of reset
    // a released rom line would otherwise float between frames
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            data_pull_reg <= 1'b1;                                  // R8
        end else begin
            data_pull_reg <= 1'b1;                                  // R8
        end
    end

    // general pin enabled once out of reset and never turned round
    // keeping it undriven in reset lets board straps settle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gpo_oe_reg <= 1'b0;
        end else begin
            gpo_oe_reg <= 1'b1;                                     // R10
        end
    end

    // outputs straight from flops
    // pad cells that combine value and enable sit outside this block
    assign rom_speed_strap_out   = data_drive_reg.out;
    assign rom_speed_strap_oe    = data_drive_reg.oe;
    assign strap_pull_down       = data_drive_reg.pull_down;
    assign data_in_pull_down     = data_pull_reg;                   // R8
    assign rom_clk               = clk_reg;
    assign rom_select_n          = select_n_reg;
    assign rom_data_bit          = data_bit_reg;
    assign fast_speed            = speed_reg;                       // R4
    assign card_slot_power       = card_reg;
    assign general_output_one    = gpo_reg;
    assign general_output_one_oe = gpo_oe_reg;                      // R10

endmodule

// ===== hdl/pin_driver.sv
`timescale 1ns/1ps

// registers one pin drive so the top's outputs come from flip-flops
module pin_driver
    import strap_pkg::*;
#(
    parameter pin_drive_type RESET_DRIVE = '0      // drive shown in reset
) (
    input  wire logic          clock,              // system clock
    input  wire logic          rstn,               // async reset, active low
    input  wire pin_drive_type drive_next,         // wanted drive
    output pin_drive_type      drive_reg           // registered drive
);

    // plain flop with constant reset value
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            drive_reg <= RESET_DRIVE;
        end else begin
            drive_reg <= drive_next;
        end
    end

endmodule

// ===== hdl/strap_pkg.sv
package strap_pkg;

    // strap encodings and serial clock rates
    localparam logic       SPEED_SLOW       = 1'h0;           // captured low
    localparam logic       SPEED_FAST       = 1'h1;           // captured high
    localparam int         SLOW_RATE_MHZ    = 30;             // slow serial rate
    localparam int         FAST_RATE_MHZ    = 60;             // fast serial rate

    // card power control field
    localparam int         CARD_PWR_LSB     = 0;              // field low bit
    localparam int         CARD_PWR_WIDTH   = 4;              // field width
    localparam logic [7:0] CARD_PWR_ADDR    = 8'hA5;          // config register address
    localparam logic [3:0] CARD_PWR_OFF     = 4'h0;           // reset value, power off

    // phases of the strap pin
    typedef enum logic [1:0] {
        PHASE_RESET   = 2'b00,     // in reset, pin floats with pull-down
        PHASE_CAPTURE = 2'b01,     // first edge after release
        PHASE_RUN     = 2'b11      // pin back to data-out role
    } strap_phase_type;

    // drive of one two-way pin
    typedef struct packed {
        logic out;                 // output value
        logic oe;                  // output enable, high drives
        logic pull_down;           // weak pull-down enable
    } pin_drive_type;

    // user-side serial port request
    typedef struct packed {
        logic clk;                 // serial clock wanted
        logic data;                // data-out bit wanted
        logic data_oe;             // data-out driven
        logic select;              // chip select wanted, active high here
    } rom_req_type;

endpackage
